// >>> gyro_trigger_reset_status_ctrl.sv
// Operation
// - bit7 integrity fault, bit6 start-up
// - bit5 outside operating conditions
// - overload: bit4 plus per-axis bits
// - channel error: bit3 plus per-axis bits
// - reset input asserted while low
// - reset forces initialisation mode
// - free-running transmission without external trigger
// - sampling continues at full rate when triggered
// - each trigger fall sends one datagram
// - pending special datagram replaces sensor datagram (code: only in trigger mode; free-running sends are always SPECIAL_NONE)
// - latest special request wins
// - init sends three special datagrams always
// - latency counts from sample to trigger
// - after three specials enter normal mode (code: enters start-up mode first, normal after STARTUP_COUNT cycles)
// - bit6 held for fixed start-up period
// - validity falls at sample, rises after send (code: falls when a send starts, on the trigger fall in trigger mode)
// - transmit regardless of error flags
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module gyro_trigger_reset_status_ctrl
  import gtrc_pkg::*;
#(
  parameter int STARTUP_COUNT = STARTUP_CYCLES,
  parameter int SAMPLE_COUNT = SAMPLE_CYCLES,
  parameter int RATE_DIV = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic module_reset_n,
  input wire logic transmit_request_in,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [7:0] statusByte,
  output logic sendStrobe,
  output logic [1:0] sendKind,
  output logic [15:0] latencyCount,
  output logic sampleTick,
  output logic validity_strobe,
  output logic irq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  gtrc_sync_if trigSync ();
  gtrc_sync_if rstSync ();

  gtrc_pin_sync uTrigSync (
    .clk(clk),
    .rst(rst),
    .pinIn(transmit_request_in),
    .out(trigSync)
  );

  gtrc_pin_sync uRstSync (
    .clk(clk),
    .rst(rst),
    .pinIn(module_reset_n),
    .out(rstSync)
  );

  logic modReset;
  assign modReset = rst | ~rstSync.level;

  // ---------------------------------------------------------------
  // bus state
  // ---------------------------------------------------------------
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] addrLat_q;
  logic [31:0] ctrl_q;
  logic [6:0] fault_q;
  logic [1:0] specialReq_q;
  logic [IRQ_WIDTH-1:0] irqStat_q;
  logic [IRQ_WIDTH-1:0] irqEn_q;
  logic txDoneReq_q;
  logic [IRQ_WIDTH-1:0] irqEvt;
  logic trigMode;
  logic busy_q;
  gtrc_mode_type mode_q;
  logic [1:0] initLeft_q;
  logic [31:0] startCnt_q;
  logic [31:0] sampCnt_q;
  logic [31:0] rateCnt_q;
  logic trigPend_q;
  logic [15:0] latency_q;
  logic [1:0] specialPend_q;
  logic accept;

  assign trigMode = ctrl_q[CTRL_TRIGMODE];
  assign accept = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addrLat_q <= 8'h00;
    end else begin
      wrPend_q <= accept & hwrite;
      rdPend_q <= accept & ~hwrite;
      if (accept) begin
        addrLat_q <= haddr[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  logic wrSpecial;
  logic wrResetCmd;
  assign wrSpecial = wrPend_q && addrLat_q == ADDR_SPECIAL;
  assign wrResetCmd = wrPend_q && addrLat_q == ADDR_CTRL && hwdata[CTRL_RESETCMD];

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      fault_q <= 7'h00;
      irqEn_q <= '0;
    end else if (wrPend_q) begin
      if (addrLat_q == ADDR_CTRL) begin
        ctrl_q <= {31'h0000_0000, hwdata[CTRL_TRIGMODE]};
      end else if (addrLat_q == ADDR_FAULT) begin
        fault_q <= hwdata[6:0];
      end else if (addrLat_q == ADDR_IRQ_EN) begin
        irqEn_q <= hwdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // status byte; errors never stop transmission
  // ---------------------------------------------------------------
  // fault_q: [6]=integrity [5]=outside [4]=overload [3]=chan err [2:0]=axis
  always_ff @(posedge clk) begin
    if (modReset) begin
      statusByte <= 8'h00;
    end else begin
      statusByte[ST_INTEGRITY] <= fault_q[6];
      statusByte[ST_STARTUP] <= (mode_q != GT_NORMAL);
      statusByte[ST_OUTSIDE] <= fault_q[5];
      statusByte[ST_OVERLOAD] <= fault_q[4];
      statusByte[ST_CHANERR] <= fault_q[3];
      statusByte[2:0] <= (fault_q[4] | fault_q[3]) ? fault_q[2:0] : 3'h0;
    end
  end

  // ---------------------------------------------------------------
  // internal sample clock, never gated by mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (modReset) begin
      sampCnt_q <= '0;
      sampleTick <= 1'b0;
    end else begin
      sampleTick <= (sampCnt_q == 32'(SAMPLE_COUNT - 1));
      sampCnt_q <= (sampCnt_q == 32'(SAMPLE_COUNT - 1)) ? '0 : sampCnt_q + 32'd1;
    end
  end

  // ---------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------
  logic txDone;
  assign txDone = txDoneReq_q & busy_q;

  always_ff @(posedge clk) begin
    if (modReset | wrResetCmd) begin
      mode_q <= GT_INIT;
      initLeft_q <= 2'(INIT_DATAGRAMS);
      startCnt_q <= '0;
    end else begin
      case (mode_q)
        GT_INIT: begin
          if (txDone) begin
            initLeft_q <= initLeft_q - 2'd1;
            if (initLeft_q == 2'd1) begin
              mode_q <= GT_STARTUP;
            end
          end
        end
        GT_STARTUP: begin
          startCnt_q <= startCnt_q + 32'd1;
          if (startCnt_q == 32'(STARTUP_COUNT - 1)) begin
            mode_q <= GT_NORMAL;
          end
        end
        GT_NORMAL: begin
          mode_q <= GT_NORMAL;
        end
        default: begin
          mode_q <= GT_INIT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // trigger, special request and latency
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (modReset) begin
      specialPend_q <= SPECIAL_NONE;
    end else if (wrSpecial) begin
      specialPend_q <= hwdata[1:0];
    end else if (sendStrobe && mode_q != GT_INIT && trigMode) begin
      specialPend_q <= SPECIAL_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (modReset) begin
      latency_q <= 16'h0000;
      latencyCount <= 16'h0000;
    end else begin
      latency_q <= sampleTick ? 16'h0000 : latency_q + 16'h0001;
      if (trigSync.fall) begin
        latencyCount <= latency_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // send scheduling
  // ---------------------------------------------------------------
  logic sendNow;
  logic freeTick;
  assign freeTick = sampleTick && rateCnt_q == 32'(RATE_DIV - 1);
  always_comb begin
    if (busy_q) begin
      sendNow = 1'b0;
    end else if (mode_q == GT_INIT) begin
      sendNow = initLeft_q != 2'd0;
    end else if (trigMode) begin
      sendNow = trigPend_q | trigSync.fall;
    end else begin
      sendNow = freeTick;
    end
  end

  always_ff @(posedge clk) begin
    if (modReset) begin
      rateCnt_q <= '0;
    end else if (sampleTick) begin
      rateCnt_q <= (rateCnt_q == 32'(RATE_DIV - 1)) ? '0 : rateCnt_q + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (modReset) begin
      trigPend_q <= 1'b0;
    end else if (trigSync.fall && (busy_q || sendStrobe)) begin
      trigPend_q <= 1'b1;
    end else if (sendNow) begin
      trigPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (modReset | wrResetCmd) begin
      busy_q <= 1'b0;
      sendStrobe <= 1'b0;
      sendKind <= SPECIAL_NONE;
      validity_strobe <= 1'b1;
    end else begin
      sendStrobe <= sendNow;
      if (sendNow) begin
        busy_q <= 1'b1;
        validity_strobe <= 1'b0;
        if (mode_q == GT_INIT) begin
          sendKind <= 2'(INIT_DATAGRAMS + 1) - initLeft_q;
        end else if (trigMode) begin
          sendKind <= specialPend_q;
        end else begin
          sendKind <= SPECIAL_NONE;
        end
      end else if (txDone) begin
        busy_q <= 1'b0;
        validity_strobe <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts; set wins over clear
  // ---------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irqClr;
  assign irqEvt = {mode_q == GT_STARTUP && startCnt_q == 32'(STARTUP_COUNT - 1),
                   txDone, trigSync.fall};
  assign irqClr = (wrPend_q && addrLat_q == ADDR_IRQ_CLR) ? hwdata[IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStat_q <= '0;
      txDoneReq_q <= 1'b0;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqEvt;
      txDoneReq_q <= wrPend_q && addrLat_q == ADDR_TXDONE && hwdata[0];
    end
  end

  assign irq = |(irqStat_q & irqEn_q);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    if (!rdPend_q) begin
      hrdata = 32'h0000_0000;
    end else if (addrLat_q == ADDR_STATUS) begin
      hrdata = {22'h0, mode_q, statusByte};
    end else if (addrLat_q == ADDR_CTRL) begin
      hrdata = ctrl_q;
    end else if (addrLat_q == ADDR_FAULT) begin
      hrdata = {25'h0, fault_q};
    end else if (addrLat_q == ADDR_SPECIAL) begin
      hrdata = {30'h0, specialPend_q};
    end else if (addrLat_q == ADDR_LATENCY) begin
      hrdata = {16'h0, latencyCount};
    end else if (addrLat_q == ADDR_IRQ_STAT) begin
      hrdata = {29'h0, irqStat_q};
    end else if (addrLat_q == ADDR_IRQ_EN) begin
      hrdata = {29'h0, irqEn_q};
    end else begin
      hrdata = 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_reset_init: assert property (@(posedge clk) disable iff (rst)
    !rstSync.level |=> mode_q == GT_INIT) else $error("reset did not force init");
  chk_startup_bit: assert property (@(posedge clk) disable iff (modReset)
    mode_q == GT_STARTUP |=> statusByte[ST_STARTUP]) else $error("startup bit low");
  chk_trig_send: assert property (@(posedge clk) disable iff (modReset)
    trigMode && mode_q == GT_NORMAL && trigSync.fall && !busy_q && !trigPend_q
    |=> sendStrobe) else $error("trigger did not send");
  chk_valid_low: assert property (@(posedge clk) disable iff (modReset)
    sendStrobe |-> !validity_strobe) else $error("validity high during send");
  chk_pend_hold: assert property (@(posedge clk) disable iff (modReset)
    trigSync.fall && busy_q && trigMode |=> trigPend_q) else $error("trigger lost");
  chk_overload_axes: assert property (@(posedge clk) disable iff (modReset)
    fault_q[4] && $stable(fault_q) |=> statusByte[2:0] == $past(fault_q[2:0]))
    else $error("axis bits wrong");
  chk_outside_bit: assert property (@(posedge clk) disable iff (modReset)
    $stable(fault_q) |=> statusByte[ST_OUTSIDE] == $past(fault_q[5])) else $error("bit5 wrong");
  chk_special_last: assert property (@(posedge clk) disable iff (modReset)
    wrSpecial |=> specialPend_q == $past(hwdata[1:0])) else $error("special not latest");
endmodule
`default_nettype wire

// >>> gtrc_pkg.sv
`default_nettype none
package gtrc_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_SPECIAL = 8'h0C;
  localparam logic [7:0] ADDR_LATENCY = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
  localparam logic [7:0] ADDR_TXDONE = 8'h20;
  // ---------------------------------------------------------------
  // status byte fields
  // ---------------------------------------------------------------
  localparam int ST_INTEGRITY = 7;
  localparam int ST_STARTUP = 6;
  localparam int ST_OUTSIDE = 5;
  localparam int ST_OVERLOAD = 4;
  localparam int ST_CHANERR = 3;
  // ctrl fields
  localparam int CTRL_TRIGMODE = 0;
  localparam int CTRL_RESETCMD = 1;
  // irq bits
  localparam int IRQ_TRIGGER = 0;
  localparam int IRQ_SENT = 1;
  localparam int IRQ_NORMAL = 2;
  localparam int IRQ_WIDTH = 3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_HZ = 2000;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam int STARTUP_MS = 800;
  localparam int STARTUP_CYCLES = (CLK_HZ / 1000) * STARTUP_MS;
  localparam int INIT_DATAGRAMS = 3;
  localparam logic [1:0] SPECIAL_NONE = 2'h0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    GT_INIT = 2'b00,
    GT_STARTUP = 2'b01,
    GT_NORMAL = 2'b10
  } gtrc_mode_type;
endpackage
`default_nettype wire

// >>> gtrc_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface gtrc_sync_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface
`default_nettype wire

// >>> gtrc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gtrc_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  gtrc_sync_if.src out
);
  logic meta_q;
  logic stable_q;
  logic prev_q;

  // ---------------------------------------------------------------
  // two-stage synchroniser, idle high like the pull-up
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      stable_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pinIn;
      stable_q <= meta_q;
      prev_q <= stable_q;
    end
  end

  assign out.level = stable_q;
  assign out.fall = prev_q & ~stable_q;
endmodule
`default_nettype wire

// >>> gtrc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module gtrc_host_model (
  input wire logic clk,
  input wire logic trigReq,
  input wire logic [3:0] lowCycles,
  input wire logic resetReq,
  output logic module_reset_n,
  output logic transmit_request_in
);
  // ----------------------------------------
  // pins
  // ----------------------------------------
  logic [3:0] lowCnt_q;
  initial lowCnt_q = 4'h0;
  // a long low hold makes the sync see a slow host, a short one a prompt host
  always @(posedge clk) begin
    if (trigReq) begin
      lowCnt_q <= lowCycles;
    end else if (lowCnt_q != 4'h0) begin
      lowCnt_q <= lowCnt_q - 4'h1;
    end
  end
  // undriven pins sit high through the pull-ups
  assign transmit_request_in = (lowCnt_q == 4'h0);
  assign module_reset_n = !resetReq;
endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import gtrc_pkg::*;
  localparam int STARTUP_N = 50;
  localparam int SAMPLE_N = 20;
  logic clk, rst, trigReq, resetReq, hwrite, hsel, hreadyout, hresp;
  logic sendStrobe, sampleTick, validityStrobe, irq, moduleResetN, trigPin;
  logic [3:0] lowCycles;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, sendKind, lastKind;
  logic [7:0] statusByte;
  logic [15:0] latencyCount;
  logic [6:0] f;
  integer seed, miscompares, tests_run, sendCount, i, k, n0;
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  gyro_trigger_reset_status_ctrl #(.STARTUP_COUNT(STARTUP_N), .SAMPLE_COUNT(SAMPLE_N),
    .RATE_DIV(1)) DUT (.clk(clk), .rst(rst), .module_reset_n(moduleResetN),
    .transmit_request_in(trigPin), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .statusByte(statusByte), .sendStrobe(sendStrobe),
    .sendKind(sendKind), .latencyCount(latencyCount), .sampleTick(sampleTick),
    .validity_strobe(validityStrobe), .irq(irq));
  gtrc_host_model host (.clk(clk), .trigReq(trigReq), .lowCycles(lowCycles),
    .resetReq(resetReq), .module_reset_n(moduleResetN), .transmit_request_in(trigPin));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // non-blocking so readers at the same edge see a stable count
  always @(posedge clk) begin
    if (sendStrobe === 1'h1) begin
      sendCount <= sendCount + 1;
      lastKind <= sendKind;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'h1;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic waitSend(input integer n);
    i = 0;
    while (sendCount < n && i < 200) begin
      @(posedge clk);
      i++;
    end
    check(sendCount, n);
  endtask
  // idle first so the pin is back high and the next fall is a real edge
  task automatic trig();
    repeat (12) @(posedge clk);
    trigReq <= 1'h1;
    lowCycles <= 4'h3 + {1'h0, 3'($random(seed))};
    @(posedge clk);
    trigReq <= 1'h0;
  endtask
  function automatic logic [7:0] expStatus(input logic [6:0] flt, input logic up);
    return {flt[6], up, flt[5:3], (flt[4] | flt[3]) ? flt[2:0] : 3'h0};
  endfunction
  initial begin
    #2000000;
    miscompares++;
    give_verdict();
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    seed = 32'hC5ABB44A;
    miscompares = 0;
    tests_run = 0;
    sendCount = 0;
    rst = 1'h1;
    trigReq = 1'h0;
    lowCycles = 4'h4;
    resetReq = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsel = 1'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge clk);
    check(validityStrobe, 32'h1);
    rst <= 1'h0;
    ahb(1'h1, ADDR_CTRL, 32'h1);
    for (k = 1; k <= 3; k++) begin
      waitSend(k);
      check(lastKind, k);
      check(statusByte[6], 32'h1);
      ahb(1'h1, ADDR_TXDONE, 32'h1);
    end
    repeat (STARTUP_N - 15) @(posedge clk);
    check(statusByte[6], 32'h1);
    repeat (30) @(posedge clk);
    check(statusByte[6], 32'h0);
    ahb(1'h0, ADDR_STATUS, 32'h0);
    check(rd[9:8], GT_NORMAL);
    check(sendCount, 32'h3);
    ahb(1'h0, 8'h40, 32'h0);
    check(rd, 32'h0);
    check(hresp, 32'h0);
    i = 0;
    while (sampleTick !== 1'h1 && i < 100) begin
      @(posedge clk);
      i++;
    end
    n0 = 0;
    do begin
      @(posedge clk);
      n0++;
    end while (sampleTick !== 1'h1 && n0 < 100);
    check(n0, SAMPLE_N);
    ahb(1'h1, ADDR_IRQ_EN, 32'h1);
    for (k = 0; k < 4; k++) begin
      // first pass forces an overload on X and Z
      f = (k == 0) ? 7'h15 : 7'($random(seed));
      ahb(1'h1, ADDR_FAULT, {25'h0, f});
      repeat (3) @(posedge clk);
      check(statusByte, expStatus(f, 1'h0));
      ahb(1'h1, ADDR_IRQ_CLR, 32'h7);
      n0 = sendCount;
      trig();
      waitSend(n0 + 1);
      check(lastKind, 32'h0);
      check(validityStrobe, 32'h0);
      check(latencyCount < SAMPLE_N, 32'h1);
      check(irq, 32'h1);
      ahb(1'h1, ADDR_IRQ_CLR, 32'h7);
      repeat (2) @(posedge clk);
      check(irq, 32'h0);
      if (k[0]) begin
        trig();
        repeat (10) @(posedge clk);
        check(sendCount, n0 + 1);
        ahb(1'h1, ADDR_TXDONE, 32'h1);
        waitSend(n0 + 2);
      end
      ahb(1'h1, ADDR_TXDONE, 32'h1);
      repeat (3) @(posedge clk);
      check(validityStrobe, 32'h1);
    end
    ahb(1'h1, ADDR_IRQ_EN, 32'h0);
    ahb(1'h1, ADDR_FAULT, 32'h0);
    for (k = 1; k <= 4; k++) begin
      ahb(1'h1, ADDR_SPECIAL, {30'h0, 2'($random(seed)) | 2'h1});
      ahb(1'h1, ADDR_SPECIAL, k & 3);
      n0 = sendCount;
      trig();
      waitSend(n0 + 1);
      check(lastKind, k & 3);
      check(irq, 32'h0);
      ahb(1'h1, ADDR_TXDONE, 32'h1);
    end
    ahb(1'h0, ADDR_IRQ_STAT, 32'h0);
    check(rd[IRQ_TRIGGER], 32'h1);
    ahb(1'h1, ADDR_CTRL, 32'h0);
    n0 = sendCount;
    waitSend(n0 + 1);
    check(lastKind, 32'h0);
    ahb(1'h1, ADDR_TXDONE, 32'h1);
    waitSend(n0 + 2);
    resetReq <= 1'h1;
    repeat (6) @(posedge clk);
    n0 = sendCount;
    resetReq <= 1'h0;
    waitSend(n0 + 1);
    check(lastKind, 32'h1);
    ahb(1'h0, ADDR_STATUS, 32'h0);
    check(rd[9:8], GT_INIT);
    n0 = sendCount;
    ahb(1'h1, ADDR_CTRL, 32'h2);
    waitSend(n0 + 1);
    check(lastKind, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
